// File: rtl/crd_map.svh
// constants for the counter readout and display control block
`ifndef CRD_MAP_SVH
`define CRD_MAP_SVH
`define CRD_NUM_CH 18
`define CRD_ROW_CHARS 16
`define CRD_NUM_ROWS 2
`define CRD_FREEZE_NS 120
`define CRD_FREEZE_CYC ((`CRD_FREEZE_NS + 7) / 8)
`define CRD_MIN_OFF_NS 120
`define CRD_MIN_OFF_CYC ((`CRD_MIN_OFF_NS + 7) / 8)
`define CRD_STRETCH_NS 10000
`define CRD_STRETCH_CYC ((`CRD_STRETCH_NS + 7) / 8)
`define CRD_HOLD_MS 3000
`define CRD_HOLD_CYC (`CRD_HOLD_MS * 125000)
`define CRD_OFS_MAX 32'sh7fffffff
`define CRD_OFS_MIN (-32'sh7fffffff)
`define CRD_MUL_ONE 32'sh000f4240
`define CRD_MUL_MAX 32'sh3b9ac9ff
`define CRD_MUL_MIN 32'sh00000001
`define CRD_ROW_RST 7'h00
`define CRD_DIV_1E6 64'sh00000000000f4240
`endif

// File: rtl/crd_pkg.sv
// types for the counter readout and display control block
package crd_pkg;
   typedef enum logic [1:0] {
      SRC_COUNT = 2'h0,
      SRC_TIMER = 2'h1,
      SRC_CPRESET = 2'h2,
      SRC_TPRESET = 2'h3
   } crd_src_t;
   typedef enum logic [3:0] {
      RUN_IDLE = 4'h1,
      RUN_ON = 4'h2,
      RUN_FREEZE = 4'h4,
      RUN_STOP = 4'h8
   } crd_run_t;
endpackage

// File: rtl/crd_ctrl.sv
// counter readout, display select, scaling and run control
// ===========================================================
// Summary of operation
// - two rows of sixteen characters, backlight
// - each row shows one of four sources
// - row may select count channel 0 to 17
// - row commands select timer or preset values
// - separate commands turn backlight on, off
// - row selections and backlight kept nonvolatile
// - scaled equals count plus offset times multiplier
// - offset signed 31-bit magnitude, default zero
// - multiplier magnitude 1e-6 to 999.999999, default one
// - unity multiplier, zero offset gives raw count
// - otherwise sign, three integer, six fraction digits
// - three second press updates, short press resets
// - run output feeds next unit gate
// - auto stop disable keeps counting past presets
// - start command begins counting
// - timer stop halts at timer preset
// - counter stop halts at count preset
// - run output high while counting
// - zero off time still lasts 120ns
// - stretch run pulses to ten microseconds
// - query reports stretch enabled or disabled
// - read halts counting 120ns while latching
// - all counters and timer freeze together
// - stop modes see no read dead time
// - out of range offset saturates
// - scaled read signed, six decimal places
`include "crd_map.svh"
`timescale 1ns/1ps
`default_nettype none
module crd_ctrl #(
   parameter int NUM_CH = `CRD_NUM_CH,
   parameter int HOLD_CYC = `CRD_HOLD_CYC
)(
   // clock and reset
   input wire logic ref_clk,
   input wire logic resetn,
   // display commands
   input wire logic upper_row_select_cmd,
   input wire logic lower_row_select_cmd,
   input wire logic [4:0] row_channel,
   input wire logic upper_row_show_timer,
   input wire logic upper_row_show_count_preset,
   input wire logic upper_row_show_timer_preset,
   input wire logic lower_row_show_timer,
   input wire logic lower_row_show_count_preset,
   input wire logic lower_row_show_timer_preset,
   input wire logic backlight_on_cmd,
   input wire logic backlight_off_cmd,
   // nonvolatile image of display settings
   input wire logic nv_valid,
   input wire logic [15:0] nv_restore,
   output logic [15:0] nv_image,
   output logic nv_save,
   // display state
   output crd_pkg::crd_src_t upper_src,
   output logic [4:0] upper_ch,
   output crd_pkg::crd_src_t lower_src,
   output logic [4:0] lower_ch,
   output logic backlight,
   // scaling
   input wire logic offset_load,
   input wire logic signed [39:0] offset_in,
   input wire logic mult_load,
   input wire logic signed [31:0] mult_in,
   input wire logic [4:0] scale_ch,
   output logic signed [63:0] scaled_value,
   output logic scaled_raw,
   // run control
   input wire logic start_cmd,
   input wire logic auto_stop_disable_cmd,
   input wire logic timer_stop_enable_cmd,
   input wire logic counter_stop_enable_cmd,
   input wire logic timer_at_preset,
   input wire logic counter_at_preset,
   input wire logic gate_in,
   input wire logic [15:0] off_time_cyc,
   output logic run_out,
   output logic count_enable,
   // pulse stretch
   input wire logic pulse_stretch_enable_cmd,
   input wire logic pulse_stretch_disable_cmd,
   input wire logic pulse_stretch_query_cmd,
   output logic [15:0] stretch_reply,
   output logic stretch_reply_valid,
   // readout freeze
   input wire logic read_cmd,
   input wire logic [NUM_CH*32-1:0] count_live,
   input wire logic [39:0] timer_live,
   output logic [NUM_CH*32-1:0] count_snap,
   output logic [39:0] timer_snap,
   output logic snap_valid,
   // front button
   input wire logic reset_or_update_button,
   output logic device_reset_req,
   output logic fw_write_mode
);
   import crd_pkg::*;
   // ===========================================================
   // display selection
   crd_src_t up_src_ff, nxt_up_src, lo_src_ff, nxt_lo_src;
   logic [4:0] up_ch_ff, nxt_up_ch, lo_ch_ff, nxt_lo_ch;
   logic bl_ff, nxt_bl, loaded_ff, nxt_loaded, save_ff, nxt_save;
   always_comb
   begin
      nxt_up_src = up_src_ff;
      nxt_up_ch = up_ch_ff;
      nxt_lo_src = lo_src_ff;
      nxt_lo_ch = lo_ch_ff;
      nxt_bl = bl_ff;
      nxt_loaded = loaded_ff;
      nxt_save = 1'b0;
      if (!loaded_ff && nv_valid)
      begin
         // restore persisted view after power up
         nxt_up_src = crd_src_t'(nv_restore[15:14]);
         nxt_up_ch = nv_restore[13:9];
         nxt_lo_src = crd_src_t'(nv_restore[8:7]);
         nxt_lo_ch = nv_restore[6:2];
         nxt_bl = nv_restore[0];
         nxt_loaded = 1'b1;
      end
      else
      begin
         if (upper_row_select_cmd && row_channel < 5'(NUM_CH))
         begin
            nxt_up_src = SRC_COUNT;
            nxt_up_ch = row_channel;
         end
         else if (upper_row_show_timer)
            nxt_up_src = SRC_TIMER;
         else if (upper_row_show_count_preset)
            nxt_up_src = SRC_CPRESET;
         else if (upper_row_show_timer_preset)
            nxt_up_src = SRC_TPRESET;
         if (lower_row_select_cmd && row_channel < 5'(NUM_CH))
         begin
            nxt_lo_src = SRC_COUNT;
            nxt_lo_ch = row_channel;
         end
         else if (lower_row_show_timer)
            nxt_lo_src = SRC_TIMER;
         else if (lower_row_show_count_preset)
            nxt_lo_src = SRC_CPRESET;
         else if (lower_row_show_timer_preset)
            nxt_lo_src = SRC_TPRESET;
         if (backlight_on_cmd)
            nxt_bl = 1'b1;
         else if (backlight_off_cmd)
            nxt_bl = 1'b0;
         nxt_save = upper_row_select_cmd | lower_row_select_cmd | upper_row_show_timer |
                    upper_row_show_count_preset | upper_row_show_timer_preset | lower_row_show_timer |
                    lower_row_show_count_preset | lower_row_show_timer_preset |
                    backlight_on_cmd | backlight_off_cmd;
      end
   end
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         up_src_ff <= SRC_COUNT;
         up_ch_ff <= 5'h00;
         lo_src_ff <= SRC_TIMER;
         lo_ch_ff <= 5'h00;
         bl_ff <= 1'b1;
         loaded_ff <= 1'b0;
         save_ff <= 1'b0;
      end
      else
      begin
         up_src_ff <= nxt_up_src;
         up_ch_ff <= nxt_up_ch;
         lo_src_ff <= nxt_lo_src;
         lo_ch_ff <= nxt_lo_ch;
         bl_ff <= nxt_bl;
         loaded_ff <= nxt_loaded;
         save_ff <= nxt_save;
      end
   end
   assign upper_src = up_src_ff;
   assign upper_ch = up_ch_ff;
   assign lower_src = lo_src_ff;
   assign lower_ch = lo_ch_ff;
   assign backlight = bl_ff;
   assign nv_image = {up_src_ff, up_ch_ff, lo_src_ff, lo_ch_ff, 1'b0, bl_ff};
   assign nv_save = save_ff;

   // ===========================================================
   // scaling parameters and result
   logic signed [31:0] ofs_ff, nxt_ofs, mul_ff, nxt_mul;
   logic signed [63:0] scl_ff, nxt_scl;
   logic raw_ff, nxt_raw;
   logic signed [33:0] sum;
   logic [31:0] sel_cnt;
   always_comb
   begin
      nxt_ofs = ofs_ff;
      nxt_mul = mul_ff;
      if (offset_load)
      begin
         if (offset_in > 40'(`CRD_OFS_MAX))
            nxt_ofs = `CRD_OFS_MAX;
         else if (offset_in < 40'(`CRD_OFS_MIN))
            nxt_ofs = `CRD_OFS_MIN;
         else
            nxt_ofs = offset_in[31:0];
      end
      if (mult_load)
      begin
         if (mult_in > `CRD_MUL_MAX)
            nxt_mul = `CRD_MUL_MAX;
         else if (mult_in < -`CRD_MUL_MAX)
            nxt_mul = -`CRD_MUL_MAX;
         else if (mult_in == 32'sh00000000)
            nxt_mul = `CRD_MUL_MIN;
         else
            nxt_mul = mult_in;
      end
      sel_cnt = count_snap[32*scale_ch +: 32];
      // two guard bits: full count plus largest offset must not wrap
      sum = $signed({2'b00, sel_cnt}) + $signed({{2{ofs_ff[31]}}, ofs_ff});
      // micro-unit result: six decimal places
      nxt_raw = (mul_ff == `CRD_MUL_ONE) && (ofs_ff == 32'sh00000000);
      if (nxt_raw)
         nxt_scl = 64'(sel_cnt);
      else
         nxt_scl = 64'(sum) * 64'(mul_ff);
   end
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         ofs_ff <= 32'sh00000000;
         mul_ff <= `CRD_MUL_ONE;
         scl_ff <= 64'sh0;
         raw_ff <= 1'b1;
      end
      else
      begin
         ofs_ff <= nxt_ofs;
         mul_ff <= nxt_mul;
         scl_ff <= nxt_scl;
         raw_ff <= nxt_raw;
      end
   end
   assign scaled_value = scl_ff;
   assign scaled_raw = raw_ff;

   // ===========================================================
   // run control, freeze and stretch
   crd_run_t st_ff, nxt_st;
   logic auto_ff, nxt_auto, ts_ff, nxt_ts, cs_ff, nxt_cs, str_ff, nxt_str;
   logic [15:0] fcnt_ff, nxt_fcnt, ocnt_ff, nxt_ocnt, wcnt_ff, nxt_wcnt;
   logic run_ff, nxt_run, snapv_ff, nxt_snapv, repv_ff, nxt_repv, stop_hit;
   logic [NUM_CH*32-1:0] csnap_ff, nxt_csnap;
   logic [39:0] tsnap_ff, nxt_tsnap;
   always_comb
   begin
      nxt_st = st_ff;
      nxt_fcnt = fcnt_ff;
      nxt_ocnt = ocnt_ff;
      nxt_csnap = csnap_ff;
      nxt_tsnap = tsnap_ff;
      nxt_snapv = 1'b0;
      nxt_auto = auto_ff;
      nxt_ts = ts_ff;
      nxt_cs = cs_ff;
      if (auto_stop_disable_cmd)
         nxt_auto = 1'b0;
      if (timer_stop_enable_cmd)
      begin
         nxt_ts = 1'b1;
         nxt_auto = 1'b1;
      end
      if (counter_stop_enable_cmd)
      begin
         nxt_cs = 1'b1;
         nxt_auto = 1'b1;
      end
      stop_hit = auto_ff && ((ts_ff && timer_at_preset) || (cs_ff && counter_at_preset));
      case (st_ff)
         RUN_IDLE:
            if (start_cmd)
               nxt_st = RUN_ON;
         RUN_ON:
            if (stop_hit)
            begin
               nxt_st = RUN_STOP;
               nxt_ocnt = (off_time_cyc < 16'(`CRD_MIN_OFF_CYC)) ? 16'(`CRD_MIN_OFF_CYC) : off_time_cyc;
            end
            else if (read_cmd)
            begin
               // one snapshot, every channel and timer together
               nxt_st = RUN_FREEZE;
               nxt_fcnt = 16'(`CRD_FREEZE_CYC);
               nxt_csnap = count_live;
               nxt_tsnap = timer_live;
            end
         RUN_FREEZE:
         begin
            nxt_fcnt = fcnt_ff - 16'h0001;
            if (fcnt_ff == 16'h0001)
            begin
               nxt_st = RUN_ON; // timer frozen too, so no dead time
               nxt_snapv = 1'b1;
            end
         end
         RUN_STOP:
         begin
            // off time counts only once run has really fallen
            if (ocnt_ff != 16'h0000)
            begin
               if (!run_ff)
                  nxt_ocnt = ocnt_ff - 16'h0001;
            end
            else if (start_cmd)
               nxt_st = RUN_ON;
         end
         default:
            nxt_st = RUN_IDLE;
      endcase
      if (read_cmd && st_ff != RUN_ON)
      begin
         nxt_csnap = count_live;
         nxt_tsnap = timer_live;
         nxt_snapv = 1'b1;
      end
      nxt_str = str_ff;
      if (pulse_stretch_enable_cmd)
         nxt_str = 1'b1;
      else if (pulse_stretch_disable_cmd)
         nxt_str = 1'b0;
      nxt_repv = pulse_stretch_query_cmd;
      // run high while counting, held only if pulse is narrow
      nxt_wcnt = wcnt_ff;
      if (st_ff == RUN_ON || st_ff == RUN_FREEZE)
      begin
         if (!run_ff)
            nxt_wcnt = 16'(`CRD_STRETCH_CYC) - 16'h0001;
         else if (wcnt_ff != 16'h0000)
            nxt_wcnt = wcnt_ff - 16'h0001;
         nxt_run = 1'b1;
      end
      else
      begin
         if (wcnt_ff != 16'h0000)
            nxt_wcnt = wcnt_ff - 16'h0001;
         nxt_run = run_ff && str_ff && (wcnt_ff != 16'h0000);
      end
   end
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         st_ff <= RUN_IDLE;
         auto_ff <= 1'b1;
         ts_ff <= 1'b0;
         cs_ff <= 1'b0;
         str_ff <= 1'b0;
         fcnt_ff <= 16'h0000;
         ocnt_ff <= 16'h0000;
         wcnt_ff <= 16'h0000;
         run_ff <= 1'b0;
         snapv_ff <= 1'b0;
         repv_ff <= 1'b0;
         csnap_ff <= '0;
         tsnap_ff <= 40'h0;
      end
      else
      begin
         st_ff <= nxt_st;
         auto_ff <= nxt_auto;
         ts_ff <= nxt_ts;
         cs_ff <= nxt_cs;
         str_ff <= nxt_str;
         fcnt_ff <= nxt_fcnt;
         ocnt_ff <= nxt_ocnt;
         wcnt_ff <= nxt_wcnt;
         run_ff <= nxt_run;
         snapv_ff <= nxt_snapv;
         repv_ff <= nxt_repv;
         csnap_ff <= nxt_csnap;
         tsnap_ff <= nxt_tsnap;
      end
   end
   assign run_out = run_ff;
   // with auto stop disabled, units count only while gate is high; otherwise gate is ignored
   assign count_enable = (st_ff == RUN_ON) && (auto_ff || gate_in);
   assign count_snap = csnap_ff;
   assign timer_snap = tsnap_ff;
   assign snap_valid = snapv_ff;
   assign stretch_reply = str_ff ? 16'h454e : 16'h4453;
   assign stretch_reply_valid = repv_ff;

   // ===========================================================
   // front button timing
   logic [31:0] bcnt_ff, nxt_bcnt;
   logic btn_ff, nxt_btn, rst_ff, nxt_rst, fw_ff, nxt_fw;
   always_comb
   begin
      nxt_btn = reset_or_update_button;
      nxt_bcnt = bcnt_ff;
      nxt_rst = 1'b0;
      nxt_fw = fw_ff;
      if (reset_or_update_button)
      begin
         if (bcnt_ff < 32'(HOLD_CYC))
            nxt_bcnt = bcnt_ff + 32'h1;
         else
            nxt_fw = 1'b1;
      end
      else
      begin
         if (btn_ff && bcnt_ff < 32'(HOLD_CYC))
            nxt_rst = 1'b1;
         nxt_bcnt = 32'h0;
      end
   end
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         bcnt_ff <= 32'h0;
         btn_ff <= 1'b0;
         rst_ff <= 1'b0;
         fw_ff <= 1'b0;
      end
      else
      begin
         bcnt_ff <= nxt_bcnt;
         btn_ff <= nxt_btn;
         rst_ff <= nxt_rst;
         fw_ff <= nxt_fw;
      end
   end
   assign device_reset_req = rst_ff;
   assign fw_write_mode = fw_ff;
endmodule // crd_ctrl
`default_nettype wire

// File: testbench/crd_ctrl_sva.sv
// assertions for the counter readout and display control block
`timescale 1ns/1ps
`default_nettype none
module crd_ctrl_sva (
   // clock and reset
   input wire logic ref_clk,
   input wire logic resetn,
   // display
   input wire logic upper_row_select_cmd,
   input wire logic lower_row_select_cmd,
   input wire logic [4:0] row_channel,
   input wire logic upper_row_show_timer,
   input wire logic lower_row_show_timer,
   input wire logic lower_row_show_count_preset,
   input wire logic lower_row_show_timer_preset,
   input wire logic backlight_on_cmd,
   input wire logic backlight_off_cmd,
   input wire crd_pkg::crd_src_t upper_src,
   input wire logic [4:0] upper_ch,
   input wire crd_pkg::crd_src_t lower_src,
   input wire logic backlight,
   // run and readout
   input wire logic read_cmd,
   input wire logic count_enable,
   input wire logic snap_valid,
   input wire logic run_out,
   // stretch
   input wire logic pulse_stretch_enable_cmd,
   input wire logic pulse_stretch_disable_cmd,
   input wire logic pulse_stretch_query_cmd,
   input wire logic [15:0] stretch_reply,
   input wire logic stretch_reply_valid
);
   import crd_pkg::*;
   localparam int STRETCH_MIN = 1250;
   logic stretch_ff;
   logic nxt_stretch;
   logic [15:0] hi_cnt_ff;
   logic [15:0] nxt_hi_cnt;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   // ==========================================
   // stretch setting and run pulse length
   always_comb
   begin
      nxt_stretch = pulse_stretch_enable_cmd | (stretch_ff & ~pulse_stretch_disable_cmd);
      nxt_hi_cnt = run_out ? ((hi_cnt_ff == 16'hffff) ? hi_cnt_ff : hi_cnt_ff + 16'h1) : 16'h0;
   end
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         stretch_ff <= 1'b0;
         hi_cnt_ff <= 16'h0;
      end
      else
      begin
         stretch_ff <= nxt_stretch;
         hi_cnt_ff <= nxt_hi_cnt;
      end
   end
   // ==========================================
   // properties
   AST_ROW_SEL: assert property (upper_row_select_cmd && row_channel < 5'h12 |=>
      upper_src == SRC_COUNT && upper_ch == $past(row_channel)) else $error("upper row channel select lost");
   AST_ROW_TIMER: assert property (upper_row_show_timer && !upper_row_select_cmd |=>
      upper_src == SRC_TIMER) else $error("upper row timer select lost");
   AST_ROW_TPRESET: assert property (lower_row_show_timer_preset && !lower_row_select_cmd &&
      !lower_row_show_timer && !lower_row_show_count_preset |=> lower_src == SRC_TPRESET)
      else $error("lower row timer preset select lost");
   AST_BL: assert property (backlight_on_cmd || backlight_off_cmd |=> backlight == $past(backlight_on_cmd))
      else $error("backlight command not applied");
   AST_FREEZE: assert property (read_cmd && count_enable |=> (!count_enable)[*8] ##1 (!count_enable)[*7])
      else $error("freeze shorter than 15 cycles");
   AST_SNAP: assert property (read_cmd && count_enable |-> ##16 snap_valid)
      else $error("snapshot not ready 16 cycles after read");
   AST_QUERY: assert property (pulse_stretch_query_cmd |=> stretch_reply_valid &&
      stretch_reply == (stretch_ff ? 16'h454e : 16'h4453)) else $error("stretch status reply wrong");
   AST_STRETCH: assert property ($fell(run_out) && stretch_ff |-> hi_cnt_ff >= STRETCH_MIN)
      else $error("run pulse narrower than 1250 cycles");
   AST_OFF_MIN: assert property ($fell(run_out) |-> (!run_out)[*8] ##1 (!run_out)[*7])
      else $error("run off time below 15 cycles");
endmodule // crd_ctrl_sva
bind crd_ctrl crd_ctrl_sva u_sva (.ref_clk, .resetn, .upper_row_select_cmd, .lower_row_select_cmd, .row_channel,
   .upper_row_show_timer, .lower_row_show_timer, .lower_row_show_count_preset, .lower_row_show_timer_preset,
   .backlight_on_cmd, .backlight_off_cmd, .upper_src, .upper_ch, .lower_src, .backlight, .read_cmd,
   .count_enable, .snap_valid, .run_out, .pulse_stretch_enable_cmd, .pulse_stretch_disable_cmd,
   .pulse_stretch_query_cmd, .stretch_reply, .stretch_reply_valid);
`default_nettype wire

// File: testbench/crd_far_model.sv
// far side model: counter datapath and upstream chained unit
`timescale 1ns/1ps
`default_nettype none
module crd_far_model (
   // clock and reset
   input wire logic ref_clk,
   input wire logic resetn,
   // bench controls
   input wire logic timer_clear,
   input wire logic preset_clear,
   input wire logic [39:0] timer_preset,
   input wire logic [31:0] count_preset,
   input wire logic upstream_run,
   // block side
   input wire logic count_enable,
   output logic [575:0] count_live,
   output logic [39:0] timer_live,
   output logic timer_at_preset,
   output logic counter_at_preset,
   output logic gate_in
);
   logic [575:0] cnt_ff;
   logic [575:0] nxt_cnt;
   logic [39:0] tmr_ff;
   logic [39:0] nxt_tmr;
   // ==========================================
   // counters and timer halt together when disabled
   always_comb
   begin
      nxt_cnt = cnt_ff;
      nxt_tmr = timer_clear ? 40'h0 : tmr_ff + {39'h0, count_enable};
      for (int i = 0; i < 18; i++)
      begin
         nxt_cnt[i*32 +: 32] = cnt_ff[i*32 +: 32] + (count_enable ? 32'(i + 1) : 32'h0);
      end
      if (preset_clear)
      begin
         nxt_cnt[255:224] = 32'h0;
      end
   end
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         cnt_ff <= '0;
         tmr_ff <= 40'h0;
      end
      else
      begin
         cnt_ff <= nxt_cnt;
         tmr_ff <= nxt_tmr;
      end
   end
   assign count_live = cnt_ff;
   assign timer_live = tmr_ff;
   assign timer_at_preset = tmr_ff >= timer_preset;
   assign counter_at_preset = cnt_ff[255:224] >= count_preset;
   assign gate_in = upstream_run;
endmodule // crd_far_model
`default_nettype wire

// File: testbench/tb.sv
// self-checking bench for the counter readout and display control block
`timescale 1ns/1ps
`default_nettype none
module tb;
   import crd_pkg::*;
   logic ref_clk = 1'b0;
   logic resetn;
   logic [21:0] cmd;
   logic [4:0] row_channel, scale_ch, upper_ch, lower_ch;
   logic signed [39:0] offset_in;
   logic signed [31:0] mult_in;
   logic signed [63:0] scaled_value;
   logic [39:0] tpre, timer_live, timer_snap, exp_tmr;
   logic [31:0] cpre, exp_cnt;
   logic [63:0] exp_val;
   logic [575:0] count_live, count_snap;
   logic [15:0] nv_image, stretch_reply, nv_mem;
   crd_src_t upper_src, lower_src;
   logic button, upstream_run, t_hit, c_hit, gate_in, backlight, scaled_raw, run_out, count_enable;
   logic stretch_reply_valid, snap_valid, device_reset_req, fw_write_mode, nv_save, nv_valid;
   int err_count = 0;
   int checks = 0;
   int n, i;
   always #4 ref_clk = ~ref_clk;
   crd_ctrl #(.NUM_CH(18), .HOLD_CYC(20)) uut (.ref_clk(ref_clk), .resetn(resetn),
      .upper_row_select_cmd(cmd[0]), .lower_row_select_cmd(cmd[1]), .row_channel(row_channel),
      .upper_row_show_timer(cmd[2]), .upper_row_show_count_preset(cmd[3]), .upper_row_show_timer_preset(cmd[4]),
      .lower_row_show_timer(cmd[5]), .lower_row_show_count_preset(cmd[6]), .lower_row_show_timer_preset(cmd[7]),
      .backlight_on_cmd(cmd[8]), .backlight_off_cmd(cmd[9]), .nv_valid(nv_valid), .nv_restore(nv_mem),
      .nv_image(nv_image), .nv_save(nv_save), .upper_src(upper_src), .upper_ch(upper_ch), .lower_src(lower_src),
      .lower_ch(lower_ch), .backlight(backlight), .offset_load(cmd[10]), .offset_in(offset_in), .mult_load(cmd[11]),
      .mult_in(mult_in), .scale_ch(scale_ch), .scaled_value(scaled_value), .scaled_raw(scaled_raw),
      .start_cmd(cmd[12]), .auto_stop_disable_cmd(cmd[13]), .timer_stop_enable_cmd(cmd[14]),
      .counter_stop_enable_cmd(cmd[15]), .timer_at_preset(t_hit), .counter_at_preset(c_hit), .gate_in(gate_in),
      .off_time_cyc(16'h0), .run_out(run_out), .count_enable(count_enable), .pulse_stretch_enable_cmd(cmd[16]),
      .pulse_stretch_disable_cmd(cmd[17]), .pulse_stretch_query_cmd(cmd[18]), .stretch_reply(stretch_reply),
      .stretch_reply_valid(stretch_reply_valid), .read_cmd(cmd[19]), .count_live(count_live),
      .timer_live(timer_live), .count_snap(count_snap), .timer_snap(timer_snap), .snap_valid(snap_valid),
      .reset_or_update_button(button), .device_reset_req(device_reset_req), .fw_write_mode(fw_write_mode));
   crd_far_model far (.ref_clk(ref_clk), .resetn(resetn), .timer_clear(cmd[20]), .preset_clear(cmd[21]),
      .timer_preset(tpre), .count_preset(cpre), .upstream_run(upstream_run), .count_enable(count_enable),
      .count_live(count_live), .timer_live(timer_live), .timer_at_preset(t_hit), .counter_at_preset(c_hit),
      .gate_in(gate_in));
   // ==========================================
   // helpers
   task chk(input logic [63:0] seen, input logic [63:0] exp);
      checks++;
      if (seen !== exp)
      begin
         err_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task pulse(input int k);
      cmd[k] = 1'b1;
      @(negedge ref_clk);
      cmd[k] = 1'b0;
   endtask
   task finish_test;
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial
   begin
      #160000;
      err_count++;
      finish_test;
   end
   // ==========================================
   // tests
   initial
   begin
      cmd = '0;
      resetn = 1'b0;
      {row_channel, scale_ch, offset_in, mult_in, button, upstream_run, nv_valid, nv_mem} = '0;
      tpre = '1;
      cpre = '1;
      repeat (20) @(negedge ref_clk);
      resetn = 1'b1;
      chk(upper_src, SRC_COUNT);
      chk(lower_src, SRC_TIMER);
      chk({backlight, run_out, scaled_raw, fw_write_mode}, 4'ha);
      $display("reset test done");
      row_channel = 5'h11;
      pulse(0);
      chk(upper_ch, 5'h11);
      chk(nv_save, 1'b1);
      chk(nv_image[15:9], 7'h11);
      row_channel = 5'h12;
      pulse(1);
      chk(lower_src, SRC_TIMER);
      chk(lower_ch, 5'h00);
      for (i = 0; i < 6; i++)
      begin
         pulse(2 + i);
         chk(i < 3 ? upper_src : lower_src, i % 3 + 1);
      end
      pulse(9);
      chk(backlight, 1'b0);
      pulse(8);
      chk(backlight, 1'b1);
      $display("display test done");
      nv_mem = nv_image;
      resetn = 1'b0;
      @(negedge ref_clk);
      chk(upper_src, SRC_COUNT);
      resetn = 1'b1;
      nv_valid = 1'b1;
      @(negedge ref_clk);
      nv_valid = 1'b0;
      chk(nv_image, nv_mem);
      $display("restore test done");
      pulse(16);
      pulse(18);
      chk({stretch_reply_valid, stretch_reply}, 17'h1454e);
      pulse(17);
      pulse(18);
      chk(stretch_reply, 16'h4453);
      pulse(12);
      @(negedge ref_clk);
      chk({run_out, count_enable}, 2'h3);
      repeat (5) @(negedge ref_clk);
      exp_cnt = count_live[63:32];
      exp_tmr = timer_live;
      pulse(19);
      chk(count_enable, 1'b0);
      for (n = 1; snap_valid !== 1'b1 && n < 40; n++) @(negedge ref_clk);
      chk(n, 16);
      chk(count_snap[63:32], exp_cnt);
      chk(timer_snap, exp_tmr);
      $display("readout test done");
      scale_ch = 5'h1;
      offset_in = 40'sh5;
      pulse(10);
      mult_in = 32'sh2625a0;
      pulse(11);
      @(negedge ref_clk);
      chk(scaled_value, (64'(exp_cnt) + 64'h5) * 64'h2625a0);
      chk(scaled_raw, 1'b0);
      offset_in = 40'sh0100000000;
      pulse(10);
      @(negedge ref_clk);
      chk(scaled_value, (64'(exp_cnt) + 64'h7fffffff) * 64'h2625a0);
      offset_in = 40'sh0;
      mult_in = 32'shf4240;
      pulse(10);
      pulse(11);
      @(negedge ref_clk);
      chk(scaled_raw, 1'b1);
      chk(scaled_value, {32'h0, exp_cnt});
      $display("scaling test done");
      tpre = 40'h28;
      pulse(20);
      pulse(14);
      for (n = 0; run_out !== 1'b0 && n < 200; n++) @(negedge ref_clk);
      exp_tmr = timer_live;
      repeat (5) @(negedge ref_clk);
      chk({run_out, count_enable}, 2'h0);
      chk(timer_live, exp_tmr);
      repeat (20) @(negedge ref_clk);
      tpre = '1;
      cpre = 32'h50;
      pulse(21);
      pulse(15);
      pulse(16);
      pulse(12);
      for (n = 0; run_out !== 1'b1 && n < 10; n++) @(negedge ref_clk);
      for (n = 0; run_out !== 1'b0 && n < 3000; n++) @(negedge ref_clk);
      chk(n >= 1250, 1'b1);
      exp_cnt = count_live[255:224];
      repeat (5) @(negedge ref_clk);
      chk(count_live[255:224], exp_cnt);
      $display("stop test done");
      repeat (20) @(negedge ref_clk);
      pulse(17);
      pulse(13);
      pulse(12);
      repeat (30) @(negedge ref_clk);
      chk({run_out, count_enable}, 2'h2);
      upstream_run = 1'b1;
      @(negedge ref_clk);
      chk(count_enable, 1'b1);
      $display("chain test done");
      button = 1'b1;
      repeat (5) @(negedge ref_clk);
      button = 1'b0;
      for (n = 0; device_reset_req !== 1'b1 && n < 10; n++) @(negedge ref_clk);
      chk({device_reset_req, fw_write_mode}, 2'h2);
      button = 1'b1;
      repeat (30) @(negedge ref_clk);
      chk(fw_write_mode, 1'b1);
      button = 1'b0;
      $display("button test done");
      finish_test;
   end
endmodule // tb
`default_nettype wire
